// file: gpio_block.sv
// Multi-port GPIO block with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module gpio_block
    import gpio_pkg::*;
#(
    parameter int ADDR_W = 10
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address and data
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // First port pins
    input wire logic [5:0] first_port_in,
    output logic [5:0] first_port_out,
    output logic [5:0] first_port_oe,
    // Second port pins
    input wire logic [7:0] second_port_in,
    output logic [7:0] second_port_out,
    output logic [7:0] second_port_oe,
    output logic [7:0] second_port_pullup_en,
    // Third port pins and peripheral override
    input wire logic [7:0] third_port_in,
    output logic [7:0] third_port_out,
    output logic [7:0] third_port_oe,
    input wire logic [7:0] third_periph_sel,
    input wire logic [7:0] third_periph_drive,
    input wire logic [7:0] third_periph_out,
    // Fourth port pins
    input wire logic [7:0] fourth_port_in,
    output logic [7:0] fourth_port_out,
    output logic [7:0] fourth_port_oe,
    // Status toward the rest of the core
    output logic parallel_slave_mode,
    output logic [5:0] analog_pin_enable,
    output logic timer_clock_out,
    output logic port_change_flag,
    output logic ext_int_flag,
    output logic wake_request
);
    // Analog pins of the first port for a config code; bit 4 is never analog
    function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
        logic [5:0] m;
        m = 6'h00;
        if (cfg == 3'h0) begin
            m = 6'h2F;
        end else if (cfg == 3'h4 || cfg == 3'h5) begin
            m = 6'h0B;
        end else if (cfg == 3'h6 || cfg == 3'h7) begin
            m = 6'h00;
        end else begin
            m = 6'h2F;
        end
        return m;
    endfunction : analog_mask

    // True for every register index the block answers
    function automatic logic is_mapped(input logic [7:0] idx);
        return idx == IDX_FIRST_DATA || idx == IDX_SECOND_DATA || idx == IDX_THIRD_DATA ||
               idx == IDX_FOURTH_DATA || idx == IDX_INT_CONTROL || idx == IDX_OPTION ||
               idx == IDX_FIRST_DIR || idx == IDX_SECOND_DIR || idx == IDX_THIRD_DIR ||
               idx == IDX_FOURTH_DIR || idx == IDX_FIFTH_DIR_STATUS || idx == IDX_ANALOG_CONFIG;
    endfunction : is_mapped

    // Register file
    logic [5:0] first_port_data_q; // Output latches
    logic [7:0] second_port_data_q;
    logic [7:0] third_port_data_q;
    logic [7:0] fourth_port_data_q;
    logic [5:0] first_port_direction_q; // 1 = input
    logic [7:0] second_port_direction_q;
    logic [7:0] third_port_direction_q;
    logic [7:0] fourth_port_direction_q;
    logic [7:0] option_control_q;
    logic [2:0] analog_pin_config_field_q;
    logic parallel_slave_mode_select_q;
    logic input_buffer_overflow_q;
    logic [2:0] fifth_port_direction_q;
    logic port_change_flag_q;
    logic ext_int_flag_q;
    // Synchronised pin levels
    logic [5:0] first_level;
    logic [7:0] second_level;
    logic [7:0] third_level;
    logic [7:0] fourth_level;
    // Change detect state
    logic [3:0] change_last_q; // Value captured at last second-port access
    logic change_mismatch;
    logic ext_prev_q;
    logic ext_edge;
    // Bus handshake state
    logic aw_held_q;
    logic w_held_q;
    logic [7:0] wr_idx_q;
    logic [7:0] wr_data_q;
    logic wr_lane_q;
    logic wr_do;
    logic ar_fire;
    logic [7:0] rd_idx;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic rvalid_q;
    logic [1:0] rresp_q;
    logic [31:0] rdata_q;
    logic [7:0] rd_word;

    // Pins are synchronised before any read or compare
    pin_sync #(.WIDTH(6)) u_sync_first (.aclk(aclk), .aresetn(aresetn), .pin_raw(first_port_in),
        .pin_level(first_level));
    pin_sync #(.WIDTH(8)) u_sync_second (.aclk(aclk), .aresetn(aresetn), .pin_raw(second_port_in),
        .pin_level(second_level));
    pin_sync #(.WIDTH(8)) u_sync_third (.aclk(aclk), .aresetn(aresetn), .pin_raw(third_port_in),
        .pin_level(third_level));
    pin_sync #(.WIDTH(8)) u_sync_fourth (.aclk(aclk), .aresetn(aresetn), .pin_raw(fourth_port_in),
        .pin_level(fourth_level));

    // Write channel: address and data accepted in either order
    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready = !w_held_q && !bvalid_q;
    assign wr_do = aw_held_q && w_held_q && !bvalid_q;

    // Hold address and data until both are in
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            wr_idx_q <= 8'h00;
            wr_data_q <= 8'h00;
            wr_lane_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_q <= 1'b1;
                wr_idx_q <= s_axi_awaddr[9:2];
            end else if (wr_do) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_q <= 1'b1;
                wr_data_q <= s_axi_wdata[7:0];
                wr_lane_q <= s_axi_wstrb[0];
            end else if (wr_do) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // Write response; unmapped index answers SLVERR
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_do) begin
            bvalid_q <= 1'b1;
            bresp_q <= is_mapped(wr_idx_q) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // Register writes; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_port_data_q <= 6'h00;
            second_port_data_q <= 8'h00;
            third_port_data_q <= 8'h00;
            fourth_port_data_q <= 8'h00;
        end else if (wr_do && wr_lane_q) begin
            // A port write lands in the latch, never on the pin directly
            if (wr_idx_q == IDX_FIRST_DATA) begin
                first_port_data_q <= wr_data_q[5:0];
            end else if (wr_idx_q == IDX_SECOND_DATA) begin
                second_port_data_q <= wr_data_q;
            end else if (wr_idx_q == IDX_THIRD_DATA) begin
                third_port_data_q <= wr_data_q;
            end else if (wr_idx_q == IDX_FOURTH_DATA) begin
                fourth_port_data_q <= wr_data_q;
            end
        end
    end

    // Direction, option and configuration registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            first_port_direction_q <= RST_FIRST_DIR;
            second_port_direction_q <= RST_PORT_DIR;
            third_port_direction_q <= RST_PORT_DIR;
            fourth_port_direction_q <= RST_PORT_DIR;
            fifth_port_direction_q <= RST_FIFTH_DIR_STATUS[2:0];
            option_control_q <= RST_OPTION;
            analog_pin_config_field_q <= RST_ANALOG_CONFIG;
            parallel_slave_mode_select_q <= RST_FIFTH_DIR_STATUS[FIFTH_PSP_MODE];
            input_buffer_overflow_q <= RST_FIFTH_DIR_STATUS[FIFTH_OVERFLOW];
        end else if (wr_do && wr_lane_q) begin
            if (wr_idx_q == IDX_FIRST_DIR) begin
                first_port_direction_q <= wr_data_q[5:0];
            end else if (wr_idx_q == IDX_SECOND_DIR) begin
                second_port_direction_q <= wr_data_q;
            end else if (wr_idx_q == IDX_THIRD_DIR) begin
                // Stores what software wrote; override acts only on the pins
                third_port_direction_q <= wr_data_q;
            end else if (wr_idx_q == IDX_FOURTH_DIR) begin
                fourth_port_direction_q <= wr_data_q;
            end else if (wr_idx_q == IDX_FIFTH_DIR_STATUS) begin
                fifth_port_direction_q <= wr_data_q[2:0];
                parallel_slave_mode_select_q <= wr_data_q[FIFTH_PSP_MODE];
                input_buffer_overflow_q <= wr_data_q[FIFTH_OVERFLOW];
            end else if (wr_idx_q == IDX_OPTION) begin
                option_control_q <= wr_data_q;
            end else if (wr_idx_q == IDX_ANALOG_CONFIG) begin
                analog_pin_config_field_q <= wr_data_q[2:0];
            end
        end
    end

    // Read path: pins for ports, zeros in unimplemented bits
    assign rd_idx = s_axi_araddr[9:2];
    assign ar_fire = s_axi_arvalid && s_axi_arready;
    assign s_axi_arready = !rvalid_q;

    // Read data mux
    always_comb begin
        rd_word = 8'h00;
        if (rd_idx == IDX_FIRST_DATA) begin
            rd_word = {2'b00, first_level & ~analog_pin_enable};
        end else if (rd_idx == IDX_SECOND_DATA) begin
            rd_word = second_level;
        end else if (rd_idx == IDX_THIRD_DATA) begin
            rd_word = third_level;
        end else if (rd_idx == IDX_FOURTH_DATA) begin
            rd_word = fourth_level;
        end else if (rd_idx == IDX_INT_CONTROL) begin
            rd_word = {6'h00, ext_int_flag_q, port_change_flag_q};
        end else if (rd_idx == IDX_OPTION) begin
            rd_word = option_control_q;
        end else if (rd_idx == IDX_FIRST_DIR) begin
            rd_word = {2'b00, first_port_direction_q};
        end else if (rd_idx == IDX_SECOND_DIR) begin
            rd_word = second_port_direction_q;
        end else if (rd_idx == IDX_THIRD_DIR) begin
            rd_word = third_port_direction_q;
        end else if (rd_idx == IDX_FOURTH_DIR) begin
            rd_word = fourth_port_direction_q;
        end else if (rd_idx == IDX_FIFTH_DIR_STATUS) begin
            // Buffer full flags stay clear: the slave handshake is not built
            rd_word = {2'b00, input_buffer_overflow_q, parallel_slave_mode_select_q, 1'b0,
                fifth_port_direction_q};
        end else if (rd_idx == IDX_ANALOG_CONFIG) begin
            rd_word = {5'h00, analog_pin_config_field_q};
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rresp_q <= RESP_OKAY;
            rdata_q <= 32'h0000_0000;
        end else if (ar_fire) begin
            rvalid_q <= 1'b1;
            rresp_q <= is_mapped(rd_idx) ? RESP_OKAY : RESP_SLVERR;
            rdata_q <= {24'h00_0000, rd_word};
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // First port: bit 4 pulls low or floats, others push-pull
    always_comb begin
        first_port_out = first_port_data_q;
        first_port_oe = ~first_port_direction_q;
        first_port_out[FIRST_TIMER_PIN] = 1'b0;
        first_port_oe[FIRST_TIMER_PIN] = ~first_port_direction_q[FIRST_TIMER_PIN] &
            ~first_port_data_q[FIRST_TIMER_PIN];
    end

    // Timer external clock taken from the open-drain pin
    assign timer_clock_out = option_control_q[OPT_TIMER_EXT_CLK] & first_level[FIRST_TIMER_PIN];
    assign analog_pin_enable = analog_mask(analog_pin_config_field_q);

    // Second port drivers and pull-ups
    assign second_port_out = second_port_data_q;
    assign second_port_oe = ~second_port_direction_q;
    // Pull-ups on only for inputs and only while the global bit is low
    assign second_port_pullup_en = {8{~option_control_q[OPT_PULLUP_DISABLE_N]}} & second_port_direction_q;

    // Third port: a selected peripheral owns direction and data
    assign third_port_out = (third_periph_sel & third_periph_out) | (~third_periph_sel & third_port_data_q);
    assign third_port_oe = (third_periph_sel & third_periph_drive) |
        (~third_periph_sel & ~third_port_direction_q);

    // Fourth port: slave-port mode releases the GPIO drivers
    assign parallel_slave_mode = parallel_slave_mode_select_q;
    assign fourth_port_out = fourth_port_data_q;
    assign fourth_port_oe = parallel_slave_mode_select_q ? 8'h00 : ~fourth_port_direction_q;

    // Mismatch of upper input pins against last captured value
    assign change_mismatch = |((second_level[7:4] ^ change_last_q) & second_port_direction_q[7:4]);

    // Any second-port read or write refreshes the compare value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            change_last_q <= second_level[7:4]; // No spurious mismatch at release
        end else if ((ar_fire && rd_idx == IDX_SECOND_DATA) || (wr_do && wr_idx_q == IDX_SECOND_DATA)) begin
            change_last_q <= second_level[7:4];
        end
    end

    // External interrupt edge: option bit 6 high picks rising
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_prev_q <= second_level[SECOND_EXT_INT_PIN]; // Matches the pin, no false edge
        end else begin
            ext_prev_q <= second_level[SECOND_EXT_INT_PIN];
        end
    end

    assign ext_edge = option_control_q[OPT_EXT_INT_EDGE] ?
        (second_level[SECOND_EXT_INT_PIN] & ~ext_prev_q) :
        (~second_level[SECOND_EXT_INT_PIN] & ext_prev_q);

    // Event flags; writing 0 clears, a set in the same cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_change_flag_q <= 1'b0;
            ext_int_flag_q <= 1'b0;
        end else begin
            if (change_mismatch) begin
                port_change_flag_q <= 1'b1;
            end else if (wr_do && wr_lane_q && wr_idx_q == IDX_INT_CONTROL && !wr_data_q[INTC_PORT_CHANGE]) begin
                port_change_flag_q <= 1'b0;
            end
            if (ext_edge) begin
                ext_int_flag_q <= 1'b1;
            end else if (wr_do && wr_lane_q && wr_idx_q == IDX_INT_CONTROL && !wr_data_q[INTC_EXT_INT]) begin
                ext_int_flag_q <= 1'b0;
            end
        end
    end

    assign port_change_flag = port_change_flag_q;
    assign ext_int_flag = ext_int_flag_q;
    // Wake needs no clock gating here; sleep logic samples this level
    assign wake_request = port_change_flag_q;

    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_second_read;
        ar_fire && rd_idx == IDX_SECOND_DATA;
    endsequence

    a_reset_dirs: assert property ($rose(aresetn) |-> second_port_direction_q == 8'hFF &&
        third_port_direction_q == 8'hFF && fourth_port_direction_q == 8'hFF && first_port_direction_q == 6'h3F)
        else $error("direction registers not all inputs after reset");
    a_open_drain: assert property (first_port_out[4] == 1'b0 && !(first_port_oe[4] && first_port_data_q[4]))
        else $error("timer pin driven high");
    a_pullup_por: assert property ($rose(aresetn) |-> second_port_pullup_en == 8'h00)
        else $error("pull-ups on after reset");
    a_pullup_output_off: assert property ((second_port_pullup_en & ~second_port_direction_q) == 8'h00)
        else $error("pull-up on an output pin");
    a_change_sets_flag: assert property (change_mismatch |=> port_change_flag_q [*1])
        else $error("mismatch did not set change flag");
    a_outputs_excluded: assert property (second_port_direction_q[7:4] == 4'h0 && !port_change_flag_q |=>
        !port_change_flag_q)
        else $error("output pin caused a mismatch");
    a_read_ends_mismatch: assert property (s_second_read ##1 $stable(second_level) |-> !change_mismatch)
        else $error("second port read left a mismatch");
    a_periph_override: assert property ((third_periph_sel & third_periph_drive) != 8'h00 |->
        (third_port_oe & third_periph_sel & third_periph_drive) == (third_periph_sel & third_periph_drive))
        else $error("peripheral drive not on pin");
    a_slave_release: assert property (parallel_slave_mode |-> fourth_port_oe == 8'h00)
        else $error("fourth port driven in slave mode");
    a_read_latency: assert property (ar_fire |=> rvalid_q ##0 (rvalid_q throughout (!s_axi_rready [*1])) or
        (rvalid_q && s_axi_rready))
        else $error("read answer not one cycle after address");
    a_ext_edge_flag: assert property (ext_edge |=> ext_int_flag_q)
        else $error("external edge did not set flag");
endmodule : gpio_block
`default_nettype wire

// file: gpio_pkg.sv
// Constants shared by the multi-port GPIO block: register indices, fields, resets
// Functional notes
// - Direction bit 1 floats pin, 0 drives
// - Reset sets every implemented direction bit
// - First port bit 4 open-drain only
// - First port bit 4 feeds timer clock
// - Option bit 7 cleared enables pull-ups
// - Output pins never get a pull-up
// - Option resets to all ones, pull-ups off
// - Only input pins take part in compare
// - OR upper mismatches into change flag bit 0
// - Mismatch keeps setting the change flag
// - Second port access refreshes compare value
// - Port change wakes device from sleep
// - Second port bit 0 is edge interrupt
// - Enabled peripheral overrides third port direction
// - Peripheral output enable only while selected
// - Mode bit turns fourth port parallel slave
// - Unimplemented bits read as zero
// - Read returns pins, write loads latch
// - Analog pins after reset read zero
// - Mode select 1 slave port, 0 GPIO
package gpio_pkg;
    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_FIRST_DATA = 8'h05;
    localparam logic [7:0] IDX_SECOND_DATA = 8'h06;
    localparam logic [7:0] IDX_THIRD_DATA = 8'h07;
    localparam logic [7:0] IDX_FOURTH_DATA = 8'h08;
    localparam logic [7:0] IDX_INT_CONTROL = 8'h0B;
    localparam logic [7:0] IDX_OPTION = 8'h81;
    localparam logic [7:0] IDX_FIRST_DIR = 8'h85;
    localparam logic [7:0] IDX_SECOND_DIR = 8'h86;
    localparam logic [7:0] IDX_THIRD_DIR = 8'h87;
    localparam logic [7:0] IDX_FOURTH_DIR = 8'h88;
    localparam logic [7:0] IDX_FIFTH_DIR_STATUS = 8'h89;
    localparam logic [7:0] IDX_ANALOG_CONFIG = 8'h9F;
    // Reset values
    localparam logic [7:0] RST_OPTION = 8'hFF;
    localparam logic [5:0] RST_FIRST_DIR = 6'h3F;
    localparam logic [7:0] RST_PORT_DIR = 8'hFF;
    localparam logic [7:0] RST_FIFTH_DIR_STATUS = 8'h07;
    localparam logic [2:0] RST_ANALOG_CONFIG = 3'h0;
    // Field positions
    localparam int OPT_PULLUP_DISABLE_N = 7;
    localparam int OPT_EXT_INT_EDGE = 6;
    localparam int OPT_TIMER_EXT_CLK = 5;
    localparam int INTC_PORT_CHANGE = 0;
    localparam int INTC_EXT_INT = 1;
    localparam int FIFTH_PSP_MODE = 4;
    localparam int FIFTH_OVERFLOW = 5;
    localparam int FIRST_TIMER_PIN = 4;
    localparam int SECOND_EXT_INT_PIN = 0;
    // Bus answers
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : gpio_pkg

// file: pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 8
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Raw pins and filtered level
    input wire logic [WIDTH-1:0] pin_raw,
    output logic [WIDTH-1:0] pin_level
);
    logic [WIDTH-1:0] s1_q; // Only read by s2_q, catches metastability
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] level_q;

    // Shift chain, one stage per edge; runs through reset so the level is settled at release
    always_ff @(posedge aclk) begin
        s1_q <= pin_raw;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end

    // A bit changes only once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            level_q <= s3_q; // Tracks the pin, so no false edge after reset
        end else begin
            for (int i = 0; i < WIDTH; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    level_q[i] <= s3_q[i];
                end
            end
        end
    end

    assign pin_level = level_q;
endmodule : pin_sync
`default_nettype wire

// file: board_model.sv
// Board-side model of the second port wire: drivers, pull-ups, floating node
`timescale 1ns/1ps
`default_nettype none
module board_model (
    // Pattern clock
    input wire logic aclk,
    // Block side of the pins
    input wire logic [7:0] pin_out,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pull_en,
    // Board drivers
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    // Resolved level
    output logic [7:0] pin_in
);
    // Floating node flips every cycle so no stale level survives
    logic [7:0] float_q = 8'h00;
    always_ff @(posedge aclk) begin
        float_q <= ~float_q;
    end
    // Block driver first, then board, then pull-up or float
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ((ext_en & ext_val) | (~ext_en & (pull_en | float_q))));
endmodule : board_model
`default_nettype wire

// file: test_multi_port_gpio_block.sv
// Register-level bench for the multi-port GPIO block
`timescale 1ns/1ps
`default_nettype none
module test_multi_port_gpio_block import gpio_pkg::*; ;
    // Bus and pins
    logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
    logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [5:0] first_port_in = 6'h3F, first_port_out, first_port_oe, analog_pin_enable;
    logic [7:0] second_port_in, second_port_out, second_port_oe, second_port_pullup_en, third_port_out;
    logic [7:0] third_port_in = 0, third_periph_sel = 0, third_periph_drive = 0, third_periph_out = 0;
    logic [7:0] third_port_oe, fourth_port_in = 0, fourth_port_out, fourth_port_oe, ext_en = 8'hFF, ext_val = 0;
    logic parallel_slave_mode, timer_clock_out, port_change_flag, ext_int_flag, wake_request;
    int errors = 0, checks_done = 0, cyc = 0;
    // Reset table
    logic [7:0] rix [7] = '{IDX_OPTION, IDX_FIRST_DIR, IDX_SECOND_DIR, IDX_THIRD_DIR, IDX_FOURTH_DIR,
        IDX_FIFTH_DIR_STATUS, IDX_ANALOG_CONFIG};
    logic [7:0] rex [7] = '{8'hFF, 8'h3F, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h00};
    gpio_block dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .first_port_in, .first_port_out,
        .first_port_oe, .second_port_in, .second_port_out, .second_port_oe, .second_port_pullup_en, .third_port_in,
        .third_port_out, .third_port_oe, .third_periph_sel, .third_periph_drive, .third_periph_out, .fourth_port_in,
        .fourth_port_out, .fourth_port_oe, .parallel_slave_mode, .analog_pin_enable, .timer_clock_out,
        .port_change_flag, .ext_int_flag, .wake_request);
    board_model board_u (.aclk, .pin_out(second_port_out), .pin_oe(second_port_oe),
        .pull_en(second_port_pullup_en), .ext_en, .ext_val, .pin_in(second_port_in));
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    // Ready sampled at the falling edge, stable until the taking edge
    task automatic wr(input logic [7:0] ix, input logic [7:0] d);
        logic a = 0;
        logic w = 0;
        @(posedge aclk);
        s_axi_awaddr <= {ix, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(negedge aclk);
            a = a | s_axi_awready;
            w = w | s_axi_wready;
            @(posedge aclk);
            s_axi_awvalid <= !a;
            s_axi_wvalid <= !w;
        end while (!(a && w));
        do @(negedge aclk); while (!s_axi_bvalid);
        @(posedge aclk);
        s_axi_bready <= 1'h0;
        @(negedge aclk);
    endtask : wr
    task automatic rd(input logic [7:0] ix);
        @(posedge aclk);
        s_axi_araddr <= {ix, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(negedge aclk); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        do @(negedge aclk); while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        @(posedge aclk);
        s_axi_rready <= 1'h0;
        @(negedge aclk);
    endtask : rd
    // Board level change, then room for the four-edge synchroniser
    task automatic pins(input logic [7:0] v);
        @(posedge aclk);
        ext_val <= v;
        repeat (8) @(negedge aclk);
    endtask : pins
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks_done++;
        if (s !== e) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, s, e);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    // Hang guard, far above the roughly 150 cycles the tests need
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            errors++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1'h1;
        for (int i = 0; i < 7; i++) begin
            rd(rix[i]);
            chk(rv, {24'h0, rex[i]});
        end
        rd(IDX_FIRST_DATA);
        chk(rv, 32'h10);
        rd(8'h40);
        chk({30'h0, rr}, {30'h0, RESP_SLVERR});
        wr(IDX_OPTION, 8'h7F);
        wr(IDX_SECOND_DATA, 8'hA5);
        wr(IDX_SECOND_DIR, 8'hF0);
        chk(32'(second_port_oe), 32'h0F);
        chk(32'(second_port_pullup_en), 32'hF0);
        pins(8'h30);
        rd(IDX_SECOND_DATA);
        chk(rv, 32'h35);
        wr(IDX_INT_CONTROL, 8'h00);
        chk(32'(port_change_flag), 32'h0);
        pins(8'h70);
        chk(32'(port_change_flag), 32'h1);
        chk(32'(wake_request), 32'h1);
        wr(IDX_INT_CONTROL, 8'h00);
        chk(32'(port_change_flag), 32'h1);
        rd(IDX_SECOND_DATA);
        wr(IDX_INT_CONTROL, 8'h00);
        chk(32'(port_change_flag), 32'h0);
        wr(IDX_SECOND_DIR, 8'h0F);
        pins(8'h70);
        chk(32'(port_change_flag), 32'h0);
        chk(32'(ext_int_flag), 32'h0);
        pins(8'h71);
        chk(32'(ext_int_flag), 32'h1);
        wr(IDX_ANALOG_CONFIG, 8'h06);
        wr(IDX_OPTION, 8'hA0);
        chk(32'(timer_clock_out), 32'h1);
        @(posedge aclk);
        first_port_in <= 6'h2F;
        repeat (8) @(negedge aclk);
        chk(32'(timer_clock_out), 32'h0);
        wr(IDX_FIRST_DIR, 8'h00);
        wr(IDX_FIRST_DATA, 8'h10);
        chk(32'(first_port_oe), 32'h2F);
        chk(32'(first_port_out), 32'h0);
        wr(IDX_FIRST_DATA, 8'h00);
        chk(32'(first_port_oe), 32'h3F);
        @(posedge aclk);
        third_periph_sel <= 8'h03;
        third_periph_drive <= 8'h01;
        third_periph_out <= 8'h01;
        wr(IDX_THIRD_DIR, 8'hFD);
        chk(32'(third_port_oe), 32'h01);
        chk(32'(third_port_out[0]), 32'h1);
        @(posedge aclk);
        third_periph_sel <= 8'h00;
        @(negedge aclk);
        chk(32'(third_port_oe), 32'h02);
        wr(IDX_FOURTH_DIR, 8'h00);
        chk(32'(fourth_port_oe), 32'hFF);
        wr(IDX_FIFTH_DIR_STATUS, 8'h17);
        chk(32'(parallel_slave_mode), 32'h1);
        chk(32'(fourth_port_oe), 32'h00);
        rd(IDX_FIFTH_DIR_STATUS);
        chk(rv, 32'h17);
        tally_and_finish();
    end
endmodule : test_multi_port_gpio_block
`default_nettype wire
